// [hw/sdseq_map.vh]
// constants and field layout of the safe run and dwell sequencer
// How it works
// [R1] a terminal becomes run-permit when its function code is 13
// [R2] with a run-permit terminal, run commands are accepted only in safe mode
// [R3] permit select 0 always permits; 1 follows the permit terminal
// [R4] stop mode 0 coasts: drive output blocked at once when permit drops
// [R5] stop mode 1 quick-stops; restart needs a fresh run command
// [R6] stop mode 2 quick-stops; a run command reentered with permit resumes
// [R7] quick-stop time 0.0 to 600.0 s, default 5.0, used in modes 1 and 2
// [R8] run: ramp to accel dwell frequency, hold, then ramp to target
// [R9] stop: ramp to decel dwell frequency, hold, then decelerate to stop
// [R10] accel dwell default 5.00 Hz, time 0.0 to 10.0 s default zero
// [R11] decel dwell default 5.00 Hz, time up to 60.0 s default zero
// [R12] a dwell with zero time or zero frequency is skipped
// [R13] only the first acceleration after a run command dwells
// [R14] decel dwell only on stop passing dwell frequency, not with brake control
// [R15] dwell before brake opening supported when control method is 0 (v/f)
// [R16] safe-stop behaviours only evaluated when permit select is 1
`ifndef SDSEQ_MAP_VH
`define SDSEQ_MAP_VH
`define SDSEQ_FUNC_RUN_EN    6'h0d
`define SDSEQ_PERMIT_ALWAYS  1'h0
`define SDSEQ_PERMIT_TERM    1'h1
`define SDSEQ_STOP_COAST     2'h0
`define SDSEQ_STOP_QSTOP     2'h1
`define SDSEQ_STOP_QRESUME   2'h2
`define SDSEQ_QSTOP_DEF      16'h0032
`define SDSEQ_QSTOP_MAX      16'h1770
`define SDSEQ_ADWELL_F_DEF   16'h01f4
`define SDSEQ_ADWELL_T_MAX   16'h0064
`define SDSEQ_DDWELL_F_DEF   16'h01f4
`define SDSEQ_DDWELL_T_MAX   16'h0258
`define SDSEQ_CTRL_VF        2'h0
`define SDSEQ_CLK_HZ         125000000
`define SDSEQ_TICK_MS        100
`define SDSEQ_TICK_CYC       ((`SDSEQ_CLK_HZ / 1000) * `SDSEQ_TICK_MS)
`define SDSEQ_APB_CTRL       12'h000
`define SDSEQ_APB_QSTOP      12'h004
`define SDSEQ_APB_ADWELL_F   12'h008
`define SDSEQ_APB_ADWELL_T   12'h00c
`define SDSEQ_APB_DDWELL_F   12'h010
`define SDSEQ_APB_DDWELL_T   12'h014
`define SDSEQ_APB_TARGET     12'h018
`define SDSEQ_APB_ACC        12'h01c
`define SDSEQ_APB_DEC        12'h020
`define SDSEQ_APB_STATUS     12'h024
`define SDSEQ_APB_FREQ       12'h028
`define SDSEQ_APB_TERMFN     12'h02c
`endif

// [hw/sdseq_sync.v]
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sdseq_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // data
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // first stage feeds only the second
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[i]   <= 1'b0;
          s2[i]   <= 1'b0;
          s3[i]   <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1[i] <= din[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            dout[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // sdseq_sync

// [hw/sdseq_top.v]
// safe run permit and dwell sequencer with apb register access
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "sdseq_map.vh"
module sdseq_top #(
  parameter NTERM    = 5,
  parameter TICK_CYC = `SDSEQ_TICK_CYC
) (
  // clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // apb slave
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  // multi-function input terminals: bit0 run, bit1 stop, rest general
  input  wire [NTERM-1:0] multi_input_terminal,
  input  wire             ext_brake_active,
  // output frequency toward the motor stage, 0.01 hz units
  output reg  [15:0]      freq_out,
  output reg              drive_enable,
  output reg              running
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  reg        permit_sel;
  reg [1:0]  stop_mode;
  reg        safe_mode;
  reg [1:0]  control_method_select;
  reg [15:0] qstop_time;
  reg [15:0] adwell_f;
  reg [15:0] adwell_t;
  reg [15:0] ddwell_f;
  reg [15:0] ddwell_t;
  reg [15:0] target_f;
  reg [15:0] acc_step;
  reg [15:0] dec_step;
  reg [6*NTERM-1:0] term_fn;
  reg [2:0]  state;

  wire [NTERM-1:0] term_s;
  sdseq_sync #(.W(NTERM)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (multi_input_terminal),
    .dout    (term_s)
  );

  // permit terminal: any terminal whose function code is run-enable
  reg       permit_cfg;
  reg       permit_in;
  integer   k;
  always @* begin
    permit_cfg = 1'b0;
    permit_in  = 1'b0;
    for (k = 0; k < NTERM; k = k + 1) begin
      if (term_fn[6*k +: 6] == `SDSEQ_FUNC_RUN_EN) begin // [R1]
        permit_cfg = 1'b1;
        permit_in  = permit_in | term_s[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait state
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;

  function [15:0] clip;
    input [15:0] v;
    input [15:0] mx;
    begin
      clip = (v > mx) ? mx : v;
    end
  endfunction

  reg [31:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_err = 1'b0;
    case (paddr)
      `SDSEQ_APB_CTRL:     rd_mux = {26'h0, control_method_select,
                                     safe_mode, stop_mode, permit_sel};
      `SDSEQ_APB_QSTOP:    rd_mux = {16'h0, qstop_time};
      `SDSEQ_APB_ADWELL_F: rd_mux = {16'h0, adwell_f};
      `SDSEQ_APB_ADWELL_T: rd_mux = {16'h0, adwell_t};
      `SDSEQ_APB_DDWELL_F: rd_mux = {16'h0, ddwell_f};
      `SDSEQ_APB_DDWELL_T: rd_mux = {16'h0, ddwell_t};
      `SDSEQ_APB_TARGET:   rd_mux = {16'h0, target_f};
      `SDSEQ_APB_ACC:      rd_mux = {16'h0, acc_step};
      `SDSEQ_APB_DEC:      rd_mux = {16'h0, dec_step};
      `SDSEQ_APB_STATUS:   rd_mux = {27'h0, permit_in, permit_cfg, state};
      `SDSEQ_APB_FREQ:     rd_mux = {16'h0, freq_out};
      `SDSEQ_APB_TERMFN:   rd_mux = {{(32-6*NTERM){1'b0}}, term_fn};
      default: begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (apb_rd) begin
        prdata <= rd_mux;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_sel            <= `SDSEQ_PERMIT_TERM;
      stop_mode             <= `SDSEQ_STOP_COAST;
      safe_mode             <= 1'b0;
      control_method_select <= `SDSEQ_CTRL_VF;
      qstop_time            <= `SDSEQ_QSTOP_DEF; // [R7]
      adwell_f              <= `SDSEQ_ADWELL_F_DEF; // [R10]
      adwell_t              <= 16'h0;
      ddwell_f              <= `SDSEQ_DDWELL_F_DEF; // [R11]
      ddwell_t              <= 16'h0;
      target_f              <= 16'h0;
      acc_step              <= 16'h0001;
      dec_step              <= 16'h0001;
      term_fn               <= {6*NTERM{1'b0}};
    end else if (apb_wr && pready) begin
      case (paddr)
        `SDSEQ_APB_CTRL: begin
          permit_sel            <= pwdata[0];
          // out-of-range stop mode is kept as coast, the safe choice
          stop_mode             <= (pwdata[2:1] == 2'h3) ?
                                   `SDSEQ_STOP_COAST : pwdata[2:1];
          safe_mode             <= pwdata[3];
          control_method_select <= pwdata[5:4];
        end
        `SDSEQ_APB_QSTOP:    qstop_time <= clip(pwdata[15:0],
                                                `SDSEQ_QSTOP_MAX);
        `SDSEQ_APB_ADWELL_F: adwell_f <= pwdata[15:0];
        `SDSEQ_APB_ADWELL_T: adwell_t <= clip(pwdata[15:0],
                                              `SDSEQ_ADWELL_T_MAX);
        `SDSEQ_APB_DDWELL_F: ddwell_f <= pwdata[15:0];
        `SDSEQ_APB_DDWELL_T: ddwell_t <= clip(pwdata[15:0],
                                              `SDSEQ_DDWELL_T_MAX);
        `SDSEQ_APB_TARGET:   target_f <= pwdata[15:0];
        `SDSEQ_APB_ACC:      acc_step <= pwdata[15:0];
        `SDSEQ_APB_DEC:      dec_step <= pwdata[15:0];
        `SDSEQ_APB_TERMFN:   term_fn  <= pwdata[6*NTERM-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 0.1 s timebase, one-cycle enable
  reg [31:0] tick_cnt;
  reg        tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYC - 1) begin
      tick_cnt <= 32'h0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  localparam ST_IDLE  = 3'h0;
  localparam ST_ACC   = 3'h1;
  localparam ST_ADW   = 3'h2;
  localparam ST_RUN   = 3'h3;
  localparam ST_DEC   = 3'h4;
  localparam ST_DDW   = 3'h5;
  localparam ST_QSTOP = 3'h6;

  reg [15:0] dwell_cnt;
  reg        acc_dwell_done;
  reg        latched_off;
  reg [15:0] qstop_step;

  wire run_cmd  = term_s[0];
  wire stop_cmd = term_s[1];
  // permit only evaluated when the terminal and selection ask for it
  wire gate_on  = permit_cfg && (permit_sel == `SDSEQ_PERMIT_TERM); // [R3] [R16]
  wire run_ok   = ~permit_cfg | safe_mode; // [R2]
  wire permit_ok = ~gate_on | permit_in; // [R3]
  wire dwell_allowed = (control_method_select == `SDSEQ_CTRL_VF); // [R15]
  wire adw_en = dwell_allowed && adwell_t != 16'h0 &&
                adwell_f != 16'h0; // [R12]
  wire ddw_en = dwell_allowed && ddwell_t != 16'h0 && ddwell_f != 16'h0 &&
                ~ext_brake_active; // [R12] [R14]

  reg run_prev;
  wire run_rise = run_cmd & ~run_prev;

  function [15:0] up_to;
    input [15:0] f;
    input [15:0] lim;
    input [15:0] stp;
    begin
      up_to = ((lim - f) > stp && lim > f) ? f + stp : lim;
    end
  endfunction

  function [15:0] down_to;
    input [15:0] f;
    input [15:0] lim;
    input [15:0] stp;
    begin
      down_to = ((f - lim) > stp && f > lim) ? f - stp : lim;
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= ST_IDLE;
      freq_out       <= 16'h0;
      drive_enable   <= 1'b0;
      running        <= 1'b0;
      dwell_cnt      <= 16'h0;
      acc_dwell_done <= 1'b0;
      latched_off    <= 1'b0;
      run_prev       <= 1'b0;
      qstop_step     <= 16'h0;
    end else begin
      run_prev <= run_cmd;
      running  <= (state != ST_IDLE);
      // quick-stop slope sized so full target reaches zero in the time
      qstop_step <= (qstop_time == 16'h0) ? 16'hffff :
                    ((target_f / qstop_time) | 16'h0001); // [R7]
      // quick stop keeps ramping to zero even if the permit comes back
      if (gate_on && !permit_in && state != ST_IDLE &&
          state != ST_QSTOP) begin
        latched_off <= 1'b1;
        if (stop_mode == `SDSEQ_STOP_COAST) begin
          state        <= ST_IDLE; // [R4]
          freq_out     <= 16'h0;
          drive_enable <= 1'b0;
        end else begin
          state <= ST_QSTOP; // [R5] [R6]
        end
      end else begin
        case (state)
          ST_IDLE: begin
            freq_out     <= 16'h0;
            drive_enable <= 1'b0;
            // mode 1 needs a new edge; mode 2 a level with permit back
            if (run_ok && permit_ok && !stop_cmd &&
                (latched_off && stop_mode == `SDSEQ_STOP_QSTOP ?
                 run_rise : run_cmd)) begin // [R5] [R6] [R2]
              latched_off    <= 1'b0;
              acc_dwell_done <= ~adw_en; // [R13]
              drive_enable   <= 1'b1;
              state          <= ST_ACC;
            end
          end
          ST_ACC: begin
            if (stop_cmd || !run_cmd) begin
              state <= ST_DEC;
            end else if (tick) begin
              if (!acc_dwell_done && freq_out >= adwell_f) begin
                freq_out  <= adwell_f; // [R8]
                dwell_cnt <= 16'h0;
                state     <= ST_ADW;
              end else if (!acc_dwell_done) begin
                freq_out <= up_to(freq_out, adwell_f, acc_step);
              end else if (freq_out >= target_f) begin
                state <= ST_RUN;
              end else begin
                freq_out <= up_to(freq_out, target_f, acc_step); // [R8]
              end
            end
          end
          ST_ADW: begin
            if (stop_cmd || !run_cmd) begin
              state <= ST_DEC;
            end else if (tick) begin
              dwell_cnt <= dwell_cnt + 16'h1;
              if (dwell_cnt + 16'h1 >= adwell_t) begin
                acc_dwell_done <= 1'b1; // [R13]
                state          <= ST_ACC;
              end
            end
          end
          ST_RUN: begin
            if (stop_cmd || !run_cmd) begin
              state <= ST_DEC;
            end else if (tick) begin
              // reference change: plain ramp, never a dwell
              if (freq_out < target_f) begin
                freq_out <= up_to(freq_out, target_f, acc_step);
              end else begin
                freq_out <= down_to(freq_out, target_f, dec_step); // [R14]
              end
            end
          end
          ST_DEC: begin
            if (run_cmd && !stop_cmd) begin
              state <= ST_ACC; // [R13] re-acceleration, no dwell
              acc_dwell_done <= 1'b1;
            end else if (tick) begin
              if (ddw_en && freq_out > ddwell_f &&
                  down_to(freq_out, 16'h0, dec_step) <= ddwell_f) begin
                freq_out  <= ddwell_f; // [R9] [R14]
                dwell_cnt <= 16'h0;
                state     <= ST_DDW;
              end else if (freq_out <= dec_step) begin
                freq_out <= 16'h0;
                state    <= ST_IDLE;
              end else begin
                freq_out <= freq_out - dec_step; // [R9]
              end
            end
          end
          ST_DDW: begin
            if (tick) begin
              dwell_cnt <= dwell_cnt + 16'h1;
              if (dwell_cnt + 16'h1 >= ddwell_t) begin
                freq_out <= down_to(freq_out, 16'h0, dec_step); // [R9]
                state    <= ST_DEC;
              end
            end
          end
          ST_QSTOP: begin
            if (tick) begin
              if (freq_out <= qstop_step) begin
                freq_out <= 16'h0;
                state    <= ST_IDLE; // [R5] [R6]
              end else begin
                freq_out <= freq_out - qstop_step; // [R7]
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sdseq_top

// [tb/sdseq_monitor.sv]
// assertion checker for the safe run and dwell sequencer
`timescale 1ns/10ps
module sdseq_monitor #(
  parameter NTERM = 5
) (
  // clock and reset
  input wire             pclk,
  input wire             presetn,
  // apb
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  // terminals and drive
  input wire [NTERM-1:0] multi_input_terminal,
  input wire [15:0]      freq_out,
  input wire             drive_enable,
  input wire             running
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////
  a_ready_one_wait: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_read_zero: assert property (
    pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  a_blocked_at_zero: assert property (
    !drive_enable |-> freq_out == 16'h0)
    else $error("frequency while blocked");
  a_coast_stays_off: assert property (
    $fell(drive_enable) |-> freq_out == 16'h0 [*8])
    else $error("output after coast");
  // steps only on the slow tick, so a change never repeats soon
  a_step_on_tick: assert property (
    $changed(freq_out) && freq_out != 16'h0 |=> $stable(freq_out) [*8])
    else $error("frequency stepped between ticks");
  a_freq_needs_run: assert property (freq_out != 16'h0 |-> running)
    else $error("frequency while not running");
  // sync delay allows a rise a few cycles after run drops
  a_rise_needs_cmd: assert property (
    freq_out > $past(freq_out) |-> $past(multi_input_terminal[0], 2)
    || $past(multi_input_terminal[0], 6))
    else $error("rise without run command");
  c_coast: cover property ($fell(drive_enable));
  c_run: cover property ($rose(running));
  c_refused: cover property (pslverr);
endmodule // sdseq_monitor

bind sdseq_top sdseq_monitor #(.NTERM(NTERM)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .multi_input_terminal(multi_input_terminal), .freq_out(freq_out),
  .drive_enable(drive_enable), .running(running));

// [tb/sdseq_term_model.sv]
// terminal model: run, stop and permit levels toward the sequencer
`timescale 1ns/10ps
module sdseq_term_model (
  // clock
  input  wire       pclk,
  // requests from the bench
  input  wire       run_req,
  input  wire       stop_req,
  input  wire       permit_req,
  // terminal levels
  output reg  [4:0] terms = 5'h00
);
  // spare terminals keep moving so no idle level can fake a decode
  reg [1:0] spare = 2'h0;
  always @(posedge pclk) begin
    spare <= spare + 2'h1;
    terms <= {spare, permit_req, stop_req, run_req};
  end
endmodule // sdseq_term_model

// [tb/sdseq_tb.sv]
// self-checking bench for the safe run and dwell sequencer
`timescale 1ns/10ps
`include "sdseq_map.vh"
module sdseq_tb;
  localparam int TK = 20;
  typedef struct {bit w; bit [11:0] a; bit [31:0] d; bit e;} sdseq_row_t;
  reg          pclk = 1'b0;
  reg          presetn = 1'b0;
  reg          psel = 1'b0;
  reg          penable = 1'b0;
  reg          pwrite = 1'b0;
  reg  [11:0]  paddr = 12'h000;
  reg  [31:0]  pwdata = 32'h0;
  reg          ext_brake_active = 1'b0;
  reg          run_req = 1'b0;
  reg          stop_req = 1'b0;
  reg          permit_req = 1'b1;
  wire [31:0]  prdata;
  wire         pready;
  wire         pslverr;
  wire [4:0]   terms;
  wire [15:0]  freq_out;
  wire         drive_enable;
  wire         running;
  logic [31:0] rd;
  logic        er;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          k;
  sdseq_row_t rows [18] = '{
    '{0, `SDSEQ_APB_CTRL, 1, 0}, '{0, `SDSEQ_APB_QSTOP, `SDSEQ_QSTOP_DEF, 0},
    '{0, `SDSEQ_APB_ADWELL_F, `SDSEQ_ADWELL_F_DEF, 0},
    '{0, `SDSEQ_APB_ADWELL_T, 0, 0},
    '{0, `SDSEQ_APB_DDWELL_F, `SDSEQ_DDWELL_F_DEF, 0},
    '{0, `SDSEQ_APB_DDWELL_T, 0, 0},
    '{1, `SDSEQ_APB_CTRL, 7, 0}, '{0, `SDSEQ_APB_CTRL, 1, 0},
    '{1, `SDSEQ_APB_QSTOP, `SDSEQ_QSTOP_MAX, 0},
    '{0, `SDSEQ_APB_QSTOP, `SDSEQ_QSTOP_MAX, 0},
    '{1, `SDSEQ_APB_ADWELL_T, `SDSEQ_ADWELL_T_MAX, 0},
    '{0, `SDSEQ_APB_ADWELL_T, `SDSEQ_ADWELL_T_MAX, 0},
    '{1, `SDSEQ_APB_DDWELL_T, `SDSEQ_DDWELL_T_MAX, 0},
    '{0, `SDSEQ_APB_DDWELL_T, `SDSEQ_DDWELL_T_MAX, 0},
    '{1, 12'h030, 5, 1}, '{0, 12'h030, 0, 1},
    '{1, `SDSEQ_APB_TARGET, 32'h3e8, 0}, '{1, `SDSEQ_APB_DDWELL_T, 4, 0}};
  sdseq_top #(.NTERM(5), .TICK_CYC(TK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .multi_input_terminal(terms),
    .ext_brake_active(ext_brake_active), .freq_out(freq_out),
    .drive_enable(drive_enable), .running(running));
  sdseq_term_model term_u (.pclk(pclk), .run_req(run_req),
    .stop_req(stop_req), .permit_req(permit_req), .terms(terms));
  initial forever #4 pclk = ~pclk;
  //////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic expire;
    chk(32'h0, 32'h1);
    final_report();
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // read just after the rising edge, pready still shows its sampled value
  task automatic apb(input bit w, input [11:0] a, input [31:0] d,
                     output logic [31:0] r, output logic e);
    int c;
    c = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      c++;
      if (c > 50) expire();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic wait_f(input [15:0] f, output int c);
    c = 0;
    while (freq_out !== f) begin
      @(negedge pclk);
      c++;
      if (c > 4000) expire();
    end
    // hand back on a rising edge so callers drive with the clock
    @(posedge pclk);
  endtask
  task automatic hold_len(input [15:0] f, output int c);
    wait_f(f, c);
    c = 0;
    while (freq_out === f && c < 400) begin @(negedge pclk); c++; end
    @(posedge pclk);
  endtask
  task automatic dwell_case(input int adt, adf, cms, brk, rc);
    int c;
    wr(`SDSEQ_APB_CTRL, cms << 4);
    wr(`SDSEQ_APB_ADWELL_T, adt);
    wr(`SDSEQ_APB_ADWELL_F, adf);
    ext_brake_active <= brk[0];
    run_req <= 1'b1;
    hold_len(16'h012c, c);
    chk(c > 3*TK/2, adt && adf && !cms);
    wait_f(16'h03e8, c);
    if (rc) wr(`SDSEQ_APB_TARGET, 32'h190);
    else begin run_req <= 1'b0; stop_req <= (adt == 0); end
    hold_len(16'h01f4, c);
    chk(c > 3*TK/2, !cms && !brk && !rc);
    run_req <= 1'b0;
    wait_f(16'h0000, c);
    stop_req <= 1'b0;
    wr(`SDSEQ_APB_TARGET, 32'h3e8);
    done("dwell");
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].w) chk(rd, rows[i].d);
      chk(er, rows[i].e);
    end
    done("registers");
    wr(`SDSEQ_APB_ACC, 32'h64);
    wr(`SDSEQ_APB_DEC, 32'h64);
    dwell_case(4, 300, 0, 0, 0);
    dwell_case(0, 300, 0, 0, 0);
    dwell_case(4, 0, 0, 0, 0);
    dwell_case(4, 300, 1, 0, 0);
    dwell_case(4, 300, 0, 1, 0);
    dwell_case(4, 300, 0, 0, 1);
    run_req <= 1'b1;
    wait_f(16'h03e8, k);
    run_req <= 1'b0;
    wait_f(16'h00c8, k);
    run_req <= 1'b1;
    hold_len(16'h012c, k);
    chk(k > 3*TK/2, 0);
    run_req <= 1'b0;
    wait_f(16'h0000, k);
    done("reaccel");
    wr(`SDSEQ_APB_TERMFN, 32'hd000);
    wr(`SDSEQ_APB_QSTOP, 32'h2);
    wr(`SDSEQ_APB_CTRL, 32'h1);
    run_req <= 1'b1;
    repeat (5*TK) @(posedge pclk);
    chk(freq_out, 0);
    run_req <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      repeat (8) @(posedge pclk);
      wr(`SDSEQ_APB_CTRL, 9 + 2*m);
      run_req <= 1'b1;
      wait_f(16'h03e8, k);
      permit_req <= 1'b0;
      repeat (8) @(posedge pclk);
      chk(drive_enable, m != 0);
      wait_f(16'h0000, k);
      if (m != 0) chk(k < 3*TK, 1);
      permit_req <= 1'b1;
      repeat (5*TK) @(posedge pclk);
      if (m != 0) chk(freq_out != 0, m == 2);
      run_req <= 1'b0;
      repeat (8) @(posedge pclk);
      run_req <= 1'b1;
      repeat (4*TK) @(posedge pclk);
      chk(freq_out != 0, 1);
      run_req <= 1'b0;
      wait_f(16'h0000, k);
      done("permit");
    end
    wr(`SDSEQ_APB_CTRL, 32'h8);
    run_req <= 1'b1;
    wait_f(16'h03e8, k);
    permit_req <= 1'b0;
    repeat (4*TK) @(posedge pclk);
    chk(freq_out, 32'h3e8);
    permit_req <= 1'b1;
    presetn <= 1'b0;
    run_req <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({freq_out, drive_enable, running}, 0);
    presetn <= 1'b1;
    apb(1'b0, `SDSEQ_APB_CTRL, 32'h0, rd, er);
    chk(rd, 1);
    done("reset");
    final_report();
  end
endmodule // sdseq_tb
